// *** rtl/uartc_pkg.sv ***
/*
 Constants, register map, field layouts and state types for the serial
 transmit/receive enable control block.
 Assumes a classic Wishbone master with 32-bit data and a single system clock.
*/
// How it works
// - Receive-full flag with its enable and its mask bit set raises the interrupt request.
// - Line-quiet flag with its enable and its mask bit set raises the interrupt request.
// - Transmitter starts pending characters with or without transmit_enable; held breaks repeat only while it is set.
// - Enabled transmitter in normal mode drives the serial output pin.
// - Internal loopback releases the serial output pin to port use.
// - Single-wire mode: single_line_dir decides whether the pin transmits or receives.
// - Writing transmit_enable zero then one queues one idle character.
// - After disable, pin stays owned until pending data, idle, break finish.
// - Receiver runs only with rx_on; otherwise input pin goes to port use.
// - Writing rx_standby one parks receiver until the wakeup condition.
// - Wakeup is idle line, or set top data bit, by wakeup method.
// - Detected wakeup clears rx_standby in hardware.
// - While break_queue and transmit_enable both stay one, further break characters keep queueing.
// - One or two breaks may result from a short break_queue pulse.
// - Character length select picks eight or nine data bits, LSB first.
// - Control register is readable and writable at any time.
package uartc_pkg;

   // ****************************************
   // Register map (index; byte address is index times four)
   // ****************************************
   localparam int          ADR_W       = 5;
   localparam logic [2:0]  IDX_CTRL    = 3'h0;
   localparam logic [2:0]  IDX_CFG     = 3'h1;
   localparam logic [2:0]  IDX_STAT    = 3'h2;
   localparam logic [2:0]  IDX_MASK    = 3'h3;
   localparam logic [2:0]  IDX_TXD     = 3'h4;
   localparam logic [2:0]  IDX_RXD     = 3'h5;

   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int          ST_RXF      = 0;
   localparam int          ST_QUIET    = 1;
   localparam int          ST_INFO_LSB = 8;
   localparam logic [7:0]  CTRL_RST    = 8'h00;
   localparam logic [7:0]  CFG_RST     = 8'h00;
   localparam logic [1:0]  MASK_RST    = 2'h0;

   // ****************************************
   // Frame timing in bit times
   // ****************************************
   localparam logic [3:0]  FRAME8_BITS = 4'hA;
   localparam logic [3:0]  FRAME9_BITS = 4'hB;
   localparam logic [3:0]  RX8_SAMPLES = 4'h9;
   localparam logic [3:0]  RX9_SAMPLES = 4'hA;
   localparam logic [10:0] SH_MARK     = 11'h7FF;
   localparam logic [10:0] BRK8_FRAME  = 11'h400;
   localparam logic [10:0] BRK9_FRAME  = 11'h000;

   typedef struct packed {
      logic [1:0] rsvd;
      logic       rx_full_irq_en;
      logic       line_quiet_irq_en;
      logic       transmit_enable;
      logic       rx_on;
      logic       rx_standby;
      logic       break_queue;
   } uartc_ctrl_t;

   typedef struct packed {
      logic [2:0] rsvd;
      logic       loopback_sel;
      logic       rx_source_sel;
      logic       single_line_dir;
      logic       char9;
      logic       wake_mark;
   } uartc_cfg_t;

   typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} uartc_tx_st_t;
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10} uartc_rx_st_t;

endpackage : uartc_pkg

// *** rtl/uartc_core.sv ***
/*
 Serial transmit/receive enable control with a minimal shifter pair,
 Wishbone classic register slave and one level interrupt.
 Assumes rxd_i and txd_i come from pins (synchronised here) and that the
 port mux outside honours the pin ownership outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module uartc_core
   import uartc_pkg::*;
#(
   parameter int unsigned BIT_DIV = 16
)(
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [ADR_W-1:0]  wb_adr_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic                   wb_ack_o,
   output logic      [31:0]       wb_dat_o,
   output logic                   irq_o,
   output logic                   txd_o,
   output logic                   txd_oe_n_o,
   input  wire logic              txd_i,
   input  wire logic              rxd_i,
   output logic                   tx_pin_owned_o,
   output logic                   rx_pin_owned_o
);

   localparam int TMW = $clog2(BIT_DIV + 1);

   // ****************************************
   // State
   // ****************************************
   uartc_ctrl_t   ctrl,     next_ctrl;
   uartc_cfg_t    cfg,      next_cfg;
   logic [1:0]    stat,     next_stat;
   logic [1:0]    mask,     next_mask;
   logic [8:0]    txb,      next_txb;
   logic          txb_full, next_txb_full;
   logic          brk_pend, next_brk_pend;
   logic          idl_pend, next_idl_pend;
   logic          ack,      next_ack;
   logic [31:0]   dat,      next_dat;
   uartc_tx_st_t  tx_st,    next_tx_st;
   logic [10:0]   tx_sh,    next_tx_sh;
   logic [3:0]    tx_cnt,   next_tx_cnt;
   logic [TMW-1:0] div_cnt, next_div_cnt;
   uartc_rx_st_t  rx_st,    next_rx_st;
   logic [TMW-1:0] rx_tm,   next_rx_tm;
   logic [3:0]    rx_n,     next_rx_n;
   logic [9:0]    rx_sh,    next_rx_sh;
   logic [8:0]    rx_data,  next_rx_data;
   logic [3:0]    q_cnt,    next_q_cnt;
   logic          armed,    next_armed;
   logic          rxd_s1, rxd_s2, txd_s1, txd_s2, rx_prev;

   logic          acc, wr, rd, bit_tick, loop_int, single_wire;
   logic          take_brk, take_idl, take_dat, tx_busy, tx_owned;
   logic          rx_line, rx_done, quiet_evt, rx_wake;
   logic [3:0]    flen, nsamp;
   logic [9:0]    rx_sh_n;

   assign acc         = wb_cyc_i & wb_stb_i & ~ack;
   assign wr          = acc & wb_we_i & wb_sel_i[0];
   assign rd          = acc & ~wb_we_i;
   assign bit_tick    = (div_cnt == '0);
   assign loop_int    = cfg.loopback_sel & ~cfg.rx_source_sel;
   assign single_wire = cfg.loopback_sel & cfg.rx_source_sel;
   assign flen        = cfg.char9 ? FRAME9_BITS : FRAME8_BITS;
   assign nsamp       = cfg.char9 ? RX9_SAMPLES : RX8_SAMPLES;
   assign tx_busy     = (tx_st == TX_SHIFT);

   // ****************************************
   // Pin ownership and interrupt
   // ****************************************
   // Pending work keeps the pin after transmit_enable falls
   assign tx_owned       = ctrl.transmit_enable | tx_busy | txb_full | brk_pend | idl_pend;
   assign tx_pin_owned_o = tx_owned & ~loop_int;
   assign txd_oe_n_o     = ~(tx_pin_owned_o & (~single_wire | cfg.single_line_dir));
   assign txd_o          = tx_sh[0];
   assign rx_pin_owned_o = ctrl.rx_on & ~cfg.loopback_sel;
   assign irq_o          = |(stat & mask & {ctrl.line_quiet_irq_en, ctrl.rx_full_irq_en});
   assign wb_ack_o       = ack;
   assign wb_dat_o       = dat;

   // ****************************************
   // Register slave
   // ****************************************
   always_comb
   begin
      next_ctrl     = ctrl;
      next_cfg      = cfg;
      next_stat     = stat;
      next_mask     = mask;
      next_txb      = txb;
      next_txb_full = txb_full & ~take_dat;
      next_brk_pend = brk_pend & ~take_brk;
      next_idl_pend = idl_pend & ~take_idl;
      next_ack      = acc;
      next_dat      = dat;
      if (rx_wake)
         next_ctrl.rx_standby = 1'b0;
      if (wr && wb_adr_i[4:2] == IDX_STAT)
         next_stat = stat & ~wb_dat_i[1:0];
      if (rd && wb_adr_i[4:2] == IDX_RXD)
         next_stat[ST_RXF] = 1'b0;
      // Set after clear so an event in the clearing cycle survives
      if (rx_done)
         next_stat[ST_RXF] = 1'b1;
      if (quiet_evt)
         next_stat[ST_QUIET] = 1'b1;
      if (wr)
      begin
         case (wb_adr_i[4:2])
            IDX_CTRL:
            begin
               next_ctrl      = uartc_ctrl_t'(wb_dat_i[7:0]);
               next_ctrl.rsvd = 2'h0;
               if (!ctrl.break_queue && wb_dat_i[0])
                  next_brk_pend = 1'b1;
               if (!ctrl.transmit_enable && wb_dat_i[3])
                  next_idl_pend = 1'b1;
            end
            IDX_CFG:
            begin
               next_cfg      = uartc_cfg_t'(wb_dat_i[7:0]);
               next_cfg.rsvd = 3'h0;
            end
            IDX_MASK:
               next_mask = wb_dat_i[1:0];
            IDX_TXD:
            begin
               next_txb      = {wb_dat_i[8] & wb_sel_i[1], wb_dat_i[7:0]};
               next_txb_full = 1'b1;
            end
            default:
               next_txb = txb;
         endcase
      end
      if (rd)
      begin
         case (wb_adr_i[4:2])
            IDX_CTRL: next_dat = {24'h0, ctrl};
            IDX_CFG:  next_dat = {24'h0, cfg};
            IDX_STAT: next_dat = {18'h0, tx_busy, txb_full, brk_pend, idl_pend,
                                  tx_pin_owned_o, rx_pin_owned_o, 6'h0, stat};
            IDX_MASK: next_dat = {30'h0, mask};
            IDX_TXD:  next_dat = {23'h0, txb};
            IDX_RXD:  next_dat = {23'h0, rx_data};
            default:  next_dat = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ctrl     <= uartc_ctrl_t'(CTRL_RST);
         cfg      <= uartc_cfg_t'(CFG_RST);
         stat     <= 2'h0;
         mask     <= MASK_RST;
         txb      <= 9'h000;
         txb_full <= 1'b0;
         brk_pend <= 1'b0;
         idl_pend <= 1'b0;
         ack      <= 1'b0;
         dat      <= 32'h0;
      end
      else
      begin
         ctrl     <= next_ctrl;
         cfg      <= next_cfg;
         stat     <= next_stat;
         mask     <= next_mask;
         txb      <= next_txb;
         txb_full <= next_txb_full;
         brk_pend <= next_brk_pend;
         idl_pend <= next_idl_pend;
         ack      <= next_ack;
         dat      <= next_dat;
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   // Break has priority over idle, idle over data; shift fills with mark
   always_comb
   begin
      next_tx_st   = tx_st;
      next_tx_sh   = tx_sh;
      next_tx_cnt  = tx_cnt;
      next_div_cnt = bit_tick ? TMW'(BIT_DIV - 1) : div_cnt - 1'b1;
      take_brk     = 1'b0;
      take_idl     = 1'b0;
      take_dat     = 1'b0;
      if (bit_tick)
      begin
         case (tx_st)
            TX_IDLE:
            begin
               next_tx_cnt = flen;
               if (brk_pend || (ctrl.break_queue && ctrl.transmit_enable))
               begin
                  take_brk   = 1'b1;
                  next_tx_sh = cfg.char9 ? BRK9_FRAME : BRK8_FRAME;
                  next_tx_st = TX_SHIFT;
               end
               else if (idl_pend)
               begin
                  take_idl   = 1'b1;
                  next_tx_sh = SH_MARK;
                  next_tx_st = TX_SHIFT;
               end
               else if (txb_full)
               begin
                  take_dat   = 1'b1;
                  next_tx_sh = {1'b1, cfg.char9 ? txb[8] : 1'b1, txb[7:0], 1'b0};
                  next_tx_st = TX_SHIFT;
               end
            end
            TX_SHIFT:
            begin
               next_tx_sh  = {1'b1, tx_sh[10:1]};
               next_tx_cnt = tx_cnt - 1'b1;
               if (tx_cnt == 4'h1)
                  next_tx_st = TX_IDLE;
            end
            default:
               next_tx_st = TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tx_st   <= TX_IDLE;
         tx_sh   <= SH_MARK;
         tx_cnt  <= 4'h0;
         div_cnt <= '0;
      end
      else
      begin
         tx_st   <= next_tx_st;
         tx_sh   <= next_tx_sh;
         tx_cnt  <= next_tx_cnt;
         div_cnt <= next_div_cnt;
      end
   end

   // ****************************************
   // Receiver
   // ****************************************
   // Internal loopback listens to the shifter, single-wire to the pin
   assign rx_line = cfg.loopback_sel ? (cfg.rx_source_sel ? txd_s2 : tx_sh[0]) : rxd_s2;
   assign rx_sh_n = {rx_line, rx_sh[9:1]};

   always_comb
   begin
      next_rx_st   = rx_st;
      next_rx_tm   = rx_tm;
      next_rx_n    = rx_n;
      next_rx_sh   = rx_sh;
      next_rx_data = rx_data;
      next_q_cnt   = q_cnt;
      next_armed   = armed;
      rx_done      = 1'b0;
      quiet_evt    = 1'b0;
      rx_wake      = 1'b0;
      case (rx_st)
         RX_IDLE:
         begin
            if (!rx_line)
               next_q_cnt = 4'h0;
            else if (bit_tick && q_cnt != flen)
            begin
               next_q_cnt = q_cnt + 1'b1;
               if (q_cnt + 1'b1 == flen)
               begin
                  if (ctrl.rx_standby && !cfg.wake_mark)
                     rx_wake = 1'b1;
                  if (armed && !ctrl.rx_standby)
                  begin
                     quiet_evt  = 1'b1;
                     next_armed = 1'b0;
                  end
               end
            end
            if (rx_prev && !rx_line)
            begin
               next_rx_st = RX_START;
               next_rx_tm = TMW'(BIT_DIV / 2);
            end
         end
         RX_START:
         begin
            next_rx_tm = rx_tm - 1'b1;
            if (rx_tm == '0)
            begin
               next_rx_st = rx_line ? RX_IDLE : RX_DATA;
               next_rx_tm = TMW'(BIT_DIV - 1);
               next_rx_n  = 4'h0;
            end
         end
         RX_DATA:
         begin
            next_rx_tm = rx_tm - 1'b1;
            if (rx_tm == '0)
            begin
               next_rx_tm = TMW'(BIT_DIV - 1);
               next_rx_sh = rx_sh_n;
               next_rx_n  = rx_n + 1'b1;
               if (rx_n + 1'b1 == nsamp)
               begin
                  next_rx_st = RX_IDLE;
                  next_q_cnt = 4'h0;
                  // Standby discards characters unless the top data bit wakes it
                  if (!ctrl.rx_standby || (cfg.wake_mark && rx_sh_n[8]))
                  begin
                     rx_wake      = ctrl.rx_standby;
                     rx_done      = 1'b1;
                     next_armed   = 1'b1;
                     next_rx_data = cfg.char9 ? rx_sh_n[8:0] : {1'b0, rx_sh_n[8:1]};
                  end
               end
            end
         end
         default:
            next_rx_st = RX_IDLE;
      endcase
      if (!ctrl.rx_on)
      begin
         next_rx_st = RX_IDLE;
         next_q_cnt = 4'h0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rxd_s1  <= 1'b1;
         rxd_s2  <= 1'b1;
         txd_s1  <= 1'b1;
         txd_s2  <= 1'b1;
         rx_prev <= 1'b1;
         rx_st   <= RX_IDLE;
         rx_tm   <= '0;
         rx_n    <= 4'h0;
         rx_sh   <= 10'h000;
         rx_data <= 9'h000;
         q_cnt   <= 4'h0;
         armed   <= 1'b0;
      end
      else
      begin
         rxd_s1  <= rxd_i;
         rxd_s2  <= rxd_s1;
         txd_s1  <= txd_i;
         txd_s2  <= txd_s1;
         rx_prev <= rx_line;
         rx_st   <= next_rx_st;
         rx_tm   <= next_rx_tm;
         rx_n    <= next_rx_n;
         rx_sh   <= next_rx_sh;
         rx_data <= next_rx_data;
         q_cnt   <= next_q_cnt;
         armed   <= next_armed;
      end
   end

endmodule : uartc_core
`default_nettype wire

// *** verif/uartc_assertions.sv ***
/*
 Port checker for uartc_core, bound to every instance.
 Assumes classic Wishbone traffic and a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module uartc_assertions
   import uartc_pkg::*;
#(
   parameter int unsigned BIT_DIV = 16
)(
   input wire logic             clk_sys_i,
   input wire logic             rst_n_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [3:0]       wb_sel_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [31:0]      wb_dat_i,
   input wire logic             wb_ack_o,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             irq_o,
   input wire logic             txd_o,
   input wire logic             txd_oe_n_o,
   input wire logic             txd_i,
   input wire logic             rxd_i,
   input wire logic             tx_pin_owned_o,
   input wire logic             rx_pin_owned_o
);
   localparam int LOW_MAX = 11 * BIT_DIV;
   localparam int BRK_MIN = 10 * BIT_DIV;
   // ****
   // Shadow of software writes, taken at the same edge as the design
   // ****
   logic [5:0]  ctrl_sh;
   logic [4:0]  cfg_sh;
   logic [1:0]  mask_sh;
   logic [15:0] low_run;
   logic        wr;
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ctrl_sh <= 6'h00;
         cfg_sh  <= 5'h00;
         mask_sh <= 2'h0;
         low_run <= 16'h0000;
      end
      else
      begin
         if (wr && wb_adr_i[4:2] == IDX_CTRL) ctrl_sh <= wb_dat_i[5:0];
         if (wr && wb_adr_i[4:2] == IDX_CFG) cfg_sh <= wb_dat_i[4:0];
         if (wr && wb_adr_i[4:2] == IDX_MASK) mask_sh <= wb_dat_i[1:0];
         low_run <= txd_o ? 16'h0000 : low_run + 16'h0001;
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ans;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   a_ack_answer: assert property (s_req |=> s_ans) else $error("ack late or too long");
   a_irq_gate: assert property (!(|(mask_sh & {ctrl_sh[4], ctrl_sh[5]})) |-> !irq_o) else $error("irq not gated");
   a_tx_off_mark: assert property (!tx_pin_owned_o && !cfg_sh[4] |-> txd_o) else $error("line busy when off");
   a_normal_drive: assert property (!cfg_sh[4] |-> txd_oe_n_o == !tx_pin_owned_o) else $error("pin drive");
   a_loop_release: assert property (cfg_sh[4] && !cfg_sh[3] |-> !tx_pin_owned_o) else $error("loop pin kept");
   a_single_dir: assert property (cfg_sh[4] && cfg_sh[3] |-> txd_oe_n_o == !(tx_pin_owned_o && cfg_sh[2]))
      else $error("single-wire direction");
   // A break ends on a low bit, so a full-length low run counts as finished
   a_release_mark: assert property ($fell(tx_pin_owned_o) && !cfg_sh[4] |->
      txd_o && ($past(txd_o) || low_run >= BRK_MIN)) else $error("pin released mid-character");
   a_rx_owner: assert property (rx_pin_owned_o == (ctrl_sh[2] && !cfg_sh[4])) else $error("rx pin owner");
   a_low_run: assert property (low_run <= LOW_MAX) else $error("low run too long");
   a_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:14] == 18'h00000) else $error("upper bits");
endmodule : uartc_assertions
bind uartc_core uartc_assertions #(.BIT_DIV(BIT_DIV)) uartc_assertions_inst (.clk_sys_i, .rst_n_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .irq_o, .txd_o, .txd_oe_n_o,
   .txd_i, .rxd_i, .tx_pin_owned_o, .rx_pin_owned_o);
`default_nettype wire

// *** verif/uartc_remote.sv ***
/*
 Remote asynchronous transceiver: sends frames on demand, decodes
 frames and breaks seen on the pin. Assumes the same bit period.
*/
`timescale 1ns/1ps
`default_nettype none
module uartc_remote #(
   parameter int unsigned BIT_DIV = 16
)(
   input  wire logic clk_i,
   input  wire logic line_i,
   input  wire logic nine_i,
   output logic      line_o
);
   logic [31:0] rx_q[$];
   int          brk_q[$];
   int          run;
   initial line_o = 1'b1;
   always @(posedge clk_i) run <= line_i ? 0 : run + 1;
   // Start, data LSB first, optional ninth bit, stop; line rests at mark
   task automatic send(input logic [8:0] v);
      int i;
      for (i = -1; i <= (nine_i ? 9 : 8); i++)
      begin
         line_o <= (i < 0) ? 1'b0 : (i == (nine_i ? 9 : 8)) ? 1'b1 : v[i];
         repeat (BIT_DIV) @(posedge clk_i);
      end
   endtask : send
   // A zero stop bit marks a break; its whole low time is recorded
   always
   begin : decode
      logic [9:0] v;
      int         i;
      @(posedge clk_i iff line_i === 1'b0);
      repeat (BIT_DIV / 2) @(posedge clk_i);
      for (i = 0; i <= (nine_i ? 9 : 8); i++)
      begin
         repeat (BIT_DIV) @(posedge clk_i);
         v[i] = line_i;
      end
      if (v[nine_i ? 9 : 8] === 1'b1)
         rx_q.push_back(nine_i ? {23'h0, v[8:0]} : {24'h0, v[7:0]});
      else
      begin
         @(posedge clk_i iff line_i === 1'b1);
         brk_q.push_back(run);
      end
   end
endmodule : uartc_remote
`default_nettype wire

// *** verif/uartc_core_bench.sv ***
/*
 Self-checking bench for uartc_core with the remote transceiver model.
 Assumes the checker file is compiled alongside and binds itself.
*/
`timescale 1ns/1ps
`default_nettype none
module uartc_core_bench;
   import uartc_pkg::*;
   localparam int unsigned DIV = 4;
   logic             clk_sys_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, nine;
   logic             txd_o, txd_oe_n_o, tx_pin_owned_o, rx_pin_owned_o, pin, rxd_line;
   logic [3:0]       wb_sel_i;
   logic [ADR_W-1:0] wb_adr_i;
   logic [31:0]      wb_dat_i, wb_dat_o, q, v;
   int               bad_count, num_checks, i;
   // Released pin floats high through its pull-up
   assign pin = txd_oe_n_o ? 1'b1 : txd_o;
   uartc_core #(.BIT_DIV(DIV)) uartc_core_inst (.clk_sys_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_sel_i,
      .wb_adr_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .irq_o, .txd_o, .txd_oe_n_o, .txd_i(pin), .rxd_i(rxd_line),
      .tx_pin_owned_o, .rx_pin_owned_o);
   uartc_remote #(.BIT_DIV(DIV)) uartc_remote_inst (.clk_i(clk_sys_i), .line_i(pin), .nine_i(nine), .line_o(rxd_line));
   initial
   begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   // ****
   // Tasks
   // ****
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task automatic fail(input string m);
      bad_count++;
      $display("ERROR %0t: %s", $time, m);
   endtask : fail
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) fail($sformatf("word %h want %h", got, exp));
   endtask : chk_word
   task automatic chk_pin(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) fail($sformatf("pin %b want %b", got, exp));
   endtask : chk_pin
   // Reserved control bits read back as zero whatever was written
   function automatic logic [31:0] exp_ctrl(input logic [31:0] w);
      return w & 32'h0000003F;
   endfunction : exp_ctrl
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      n = 0;
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 100);
      if (n == 100)
      begin
         fail("no ack");
         wrap_up();
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : bus
   task automatic wait_reg(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      int n;
      for (n = 0; n < 3000; n++)
      begin
         bus(1'b0, a, 32'h0);
         if ((q & m) === e) return;
      end
      fail("poll timeout");
      wrap_up();
   endtask : wait_reg
   task automatic wait_q(input int k);
      int n;
      for (n = 0; n < 5000 && uartc_remote_inst.rx_q.size() + uartc_remote_inst.brk_q.size() < k; n++)
         @(posedge clk_sys_i);
      if (n == 5000)
      begin
         fail("frame timeout");
         wrap_up();
      end
   endtask : wait_q
   // ****
   // Main sequence
   // ****
   initial
   begin
      rst_n_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_sel_i = 4'h0;
      wb_adr_i = 5'h00;
      wb_dat_i = 32'h0;
      nine = 1'b0;
      i = $urandom(56);
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      bus(1'b0, 5'h00, 32'h0);
      chk_word(q, {24'h0, CTRL_RST});
      bus(1'b0, 5'h04, 32'h0);
      chk_word(q, {24'h0, CFG_RST});
      bus(1'b1, 5'h18, 32'hFFFFFFFF);
      bus(1'b0, 5'h18, 32'h0);
      chk_word(q, 32'h0);
      for (i = 0; i < 4; i++)
      begin
         v = $urandom & 32'hF4;
         bus(1'b1, 5'h00, v);
         bus(1'b0, 5'h00, 32'h0);
         chk_word(q, exp_ctrl(v));
      end
      // Frames in both lengths with random data
      bus(1'b1, 5'h00, 32'h08);
      for (i = 0; i < 4; i++)
      begin
         nine <= i[1];
         bus(1'b1, 5'h04, {30'h0, i[1], 1'b0});
         v = $urandom & (i[1] ? 32'h1FF : 32'hFF);
         uartc_remote_inst.rx_q.delete();
         bus(1'b1, 5'h10, v);
         wait_q(1);
         chk_word(uartc_remote_inst.rx_q[0], v);
      end
      nine <= 1'b0;
      bus(1'b1, 5'h04, 32'h0);
      // Disable and re-enable in mid-character
      uartc_remote_inst.rx_q.delete();
      bus(1'b1, 5'h10, 32'hA5);
      bus(1'b1, 5'h00, 32'h00);
      chk_pin(tx_pin_owned_o, 1'b1);
      bus(1'b1, 5'h00, 32'h08);
      bus(1'b0, 5'h08, 32'h0);
      chk_pin(q[10], 1'b1);
      bus(1'b1, 5'h00, 32'h00);
      wait_reg(5'h08, 32'h3E00, 32'h0);
      chk_pin(tx_pin_owned_o, 1'b0);
      chk_word(uartc_remote_inst.rx_q.size(), 32'h1);
      // Held break, then a short pulse in nine-bit frames
      uartc_remote_inst.rx_q.delete();
      uartc_remote_inst.brk_q.delete();
      bus(1'b1, 5'h00, 32'h09);
      wait_q(3);
      bus(1'b1, 5'h00, 32'h08);
      wait_reg(5'h08, 32'h3C00, 32'h0);
      chk_word(uartc_remote_inst.brk_q[0], 10 * DIV);
      chk_pin(uartc_remote_inst.brk_q.size() >= 3, 1'b1);
      nine <= 1'b1;
      bus(1'b1, 5'h04, 32'h02);
      uartc_remote_inst.brk_q.delete();
      bus(1'b1, 5'h00, 32'h09);
      bus(1'b1, 5'h00, 32'h08);
      wait_reg(5'h08, 32'h3C00, 32'h0);
      chk_pin(uartc_remote_inst.brk_q.size() inside {1, 2}, 1'b1);
      chk_word(uartc_remote_inst.brk_q[0], 11 * DIV);
      nine <= 1'b0;
      bus(1'b1, 5'h04, 32'h0);
      bus(1'b1, 5'h00, 32'h0);
      // Receive with interrupts
      bus(1'b1, 5'h0C, 32'h3);
      bus(1'b1, 5'h00, 32'h24);
      chk_pin(rx_pin_owned_o, 1'b1);
      v = $urandom & 32'hFF;
      uartc_remote_inst.send(v[8:0]);
      wait_reg(5'h08, 32'h1, 32'h1);
      chk_pin(irq_o, 1'b1);
      bus(1'b0, 5'h14, 32'h0);
      chk_word(q, v);
      wait_reg(5'h08, 32'h3, 32'h2);
      chk_pin(irq_o, 1'b0);
      bus(1'b1, 5'h00, 32'h34);
      chk_pin(irq_o, 1'b1);
      bus(1'b1, 5'h08, 32'h2);
      chk_pin(irq_o, 1'b0);
      bus(1'b1, 5'h00, 32'h04);
      uartc_remote_inst.send(9'h03C);
      wait_reg(5'h08, 32'h1, 32'h1);
      chk_pin(irq_o, 1'b0);
      bus(1'b0, 5'h14, 32'h0);
      bus(1'b1, 5'h00, 32'h00);
      chk_pin(rx_pin_owned_o, 1'b0);
      uartc_remote_inst.send(9'h0C3);
      bus(1'b0, 5'h08, 32'h0);
      chk_pin(q[0], 1'b0);
      // Standby with address-mark, then idle-line wakeup
      bus(1'b1, 5'h04, 32'h01);
      bus(1'b1, 5'h00, 32'h06);
      uartc_remote_inst.send(v[8:0] & 9'h07F);
      bus(1'b0, 5'h08, 32'h0);
      chk_pin(q[0], 1'b0);
      uartc_remote_inst.send(v[8:0] | 9'h080);
      wait_reg(5'h08, 32'h1, 32'h1);
      bus(1'b0, 5'h00, 32'h0);
      chk_pin(q[1], 1'b0);
      bus(1'b0, 5'h14, 32'h0);
      chk_word(q, v | 32'h80);
      bus(1'b1, 5'h04, 32'h00);
      bus(1'b1, 5'h00, 32'h06);
      uartc_remote_inst.send(9'h0FF);
      wait_reg(5'h00, 32'h2, 32'h0);
      bus(1'b0, 5'h08, 32'h0);
      chk_pin(q[0], 1'b0);
      // Pin ownership in loop and single-wire modes
      bus(1'b1, 5'h00, 32'h08);
      bus(1'b1, 5'h04, 32'h10);
      chk_pin(tx_pin_owned_o, 1'b0);
      for (i = 0; i < 2; i++)
      begin
         bus(1'b1, 5'h04, 32'h18 | (i << 2));
         chk_pin(txd_oe_n_o, !i[0]);
      end
      bus(1'b1, 5'h04, 32'h00);
      chk_pin(txd_oe_n_o, 1'b0);
      wrap_up();
   end
endmodule : uartc_core_bench
`default_nettype wire
